// [verilog/dpcu_pkg.sv]
package dpcu_pkg;

  // Widths and counts
  localparam int CW     = 16;
  localparam int NUNIT  = 2;
  localparam int NMC    = 4;
  localparam int NMCIN  = 16;
  localparam int SELW   = 4;
  localparam int NUPIN  = 2 * NUNIT;
  localparam int NIN    = NUPIN + NMCIN;
  localparam int NINT   = 10;
  localparam int CTRLW  = 7;
  localparam int MCW    = 28;
  localparam int AW     = 7;

  localparam logic [CW-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;

  // Per-unit window: unit g sits at g * UNIT_STRIDE
  localparam logic [AW-1:0] UNIT_STRIDE = 7'h20;
  localparam logic [4:0]    U_CTRL      = 5'h00;
  localparam logic [4:0]    U_PERIOD    = 5'h04;
  localparam logic [4:0]    U_DUTYA     = 5'h08;
  localparam logic [4:0]    U_DUTYB     = 5'h0C;
  localparam logic [4:0]    U_CAPT      = 5'h10;
  localparam logic [4:0]    U_LOAD      = 5'h14;
  localparam logic [4:0]    U_CNT       = 5'h18;
  localparam int            UNIT_BIT    = 5;

  localparam logic [AW-1:0] MC_CTRL  = 7'h40;
  localparam logic [AW-1:0] MC_SW    = 7'h44;
  localparam logic [AW-1:0] MC_CAPTURE_CHANNEL_ZERO  = 7'h48;
  localparam logic [AW-1:0] MC_STEP  = 7'h04;
  localparam logic [AW-1:0] INT_STAT = 7'h58;
  localparam logic [AW-1:0] INT_EN   = 7'h5C;
  localparam logic [AW-1:0] INT_CLR  = 7'h60;

  // Unit control fields
  localparam int B_EN     = 0;
  localparam int B_MODE   = 1;
  localparam int B_CAPSEL = 2;
  localparam int B_METH   = 3;
  localparam int B_POLA   = 5;
  localparam int B_POLB   = 6;
  localparam int B_START  = 7;
  localparam int B_BUSY   = 8;

  // Multi-channel capture control fields
  localparam int B_MC_EN   = 0;
  localparam int B_MC_SW   = 1;
  localparam int B_MC_LINK = 2;
  localparam int B_MC_SEL  = 4;
  localparam int B_MC_EDGE = 20;

  // Interrupt status layout
  localparam int I_PWM = 0;
  localparam int I_CAP = 2;
  localparam int I_MC  = 4;
  localparam int I_OVF = 8;

  typedef enum logic [1:0] {
    METH_SW_RISE   = 2'h0,
    METH_SW_FALL   = 2'h1,
    METH_RISE_FALL = 2'h2,
    METH_FALL_RISE = 2'h3
  } dpcu_meth_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM  = 4'h2,
    ST_RUN  = 4'h4,
    ST_DONE = 4'h8
  } dpcu_state_t;

endpackage

// [verilog/dpcu_unit_if.sv]
`timescale 1ns/1ps
interface dpcu_unit_if;
  import dpcu_pkg::*;
  logic          en;
  logic          cap_mode;
  logic          capsel;
  logic          pola;
  logic          polb;
  logic          start;
  logic          load;
  logic          rise_a;
  logic          fall_a;
  logic          rise_b;
  logic          fall_b;
  dpcu_meth_t    meth;
  logic [CW-1:0] period;
  logic [CW-1:0] duty_a;
  logic [CW-1:0] duty_b;
  logic [CW-1:0] load_val;
  logic [CW-1:0] cnt;
  logic [CW-1:0] cap_val;
  logic          pwm_a;
  logic          pwm_b;
  logic          ev_period;
  logic          ev_cap;
  logic          ev_ovf;
  logic          busy;

  modport ctl (output en, cap_mode, capsel, pola, polb, start, load, rise_a, fall_a, rise_b, fall_b,
               output meth, period, duty_a, duty_b, load_val,
               input  cnt, cap_val, pwm_a, pwm_b, ev_period, ev_cap, ev_ovf, busy);
  modport unit (input  en, cap_mode, capsel, pola, polb, start, load, rise_a, fall_a, rise_b, fall_b,
                input  meth, period, duty_a, duty_b, load_val,
                output cnt, cap_val, pwm_a, pwm_b, ev_period, ev_cap, ev_ovf, busy);
endinterface

// [verilog/dpcu_unit.sv]
`timescale 1ns/1ps
module dpcu_unit
  import dpcu_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  // Control and status
  dpcu_unit_if.unit u
);

  dpcu_state_t   state_ff;
  dpcu_state_t   nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] cap_ff;
  logic          pwm_a_ff;
  logic          pwm_b_ff;
  logic          ev_per_ff;
  logic          ev_cap_ff;
  logic          ev_ovf_ff;
  logic          sel_rise;
  logic          sel_fall;
  logic          start_edge;
  logic          cap_edge;
  logic          edge_start;
  logic          wrap;
  logic          counting;

  always_comb begin
    sel_rise   = u.capsel ? u.rise_b : u.rise_a;
    sel_fall   = u.capsel ? u.fall_b : u.fall_a;
    edge_start = (u.meth == METH_RISE_FALL) || (u.meth == METH_FALL_RISE);
    start_edge = (u.meth == METH_RISE_FALL) ? sel_rise : sel_fall;
    cap_edge   = ((u.meth == METH_SW_RISE) || (u.meth == METH_FALL_RISE)) ? sel_rise : sel_fall;
    wrap       = cnt_ff >= u.period;
    counting   = u.cap_mode ? ((state_ff == ST_RUN) && !cap_edge) : !wrap;
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE, ST_DONE: begin
        if (u.start) begin
          nxt_state = edge_start ? ST_ARM : ST_RUN;
        end
      end
      ST_ARM: begin
        if (start_edge) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cap_edge) begin
          nxt_state = ST_DONE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!u.en || !u.cap_mode) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff <= ST_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // Link load has priority so a multi-channel capture reloads the first unit's counter from its load value
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_ff <= CNT_ZERO;
    end else if (ce_i) begin
      if (!u.en) begin
        cnt_ff <= CNT_ZERO;
      end else if (u.load) begin
        cnt_ff <= u.load_val;
      end else if (!u.cap_mode) begin
        cnt_ff <= wrap ? CNT_ZERO : cnt_ff + 1'b1;
      end else if (nxt_state == ST_RUN && state_ff != ST_RUN) begin
        cnt_ff <= CNT_ZERO;
      end else if (counting) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cap_ff <= CNT_ZERO;
    end else if (ce_i && u.en && state_ff == ST_RUN && cap_edge) begin
      cap_ff <= cnt_ff;
    end
  end

  // Idle output rests at the inactive level, which the polarity bit sets
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pwm_a_ff <= 1'b0;
      pwm_b_ff <= 1'b0;
    end else if (ce_i) begin
      pwm_a_ff <= ((u.en && !u.cap_mode) && (cnt_ff < u.duty_a)) ^ u.pola;
      pwm_b_ff <= ((u.en && !u.cap_mode) && (cnt_ff < u.duty_b)) ^ u.polb;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ev_per_ff <= 1'b0;
      ev_cap_ff <= 1'b0;
      ev_ovf_ff <= 1'b0;
    end else if (ce_i) begin
      ev_per_ff <= u.en && !u.cap_mode && !u.load && wrap;
      ev_cap_ff <= u.en && state_ff == ST_RUN && cap_edge;
      ev_ovf_ff <= u.en && !u.load && counting && cnt_ff == CNT_MAX;
    end
  end

  assign u.cnt       = cnt_ff;
  assign u.cap_val   = cap_ff;
  assign u.pwm_a     = pwm_a_ff;
  assign u.pwm_b     = pwm_b_ff;
  assign u.ev_period = ev_per_ff;
  assign u.ev_cap    = ev_cap_ff;
  assign u.ev_ovf    = ev_ovf_ff;
  assign u.busy      = (state_ff == ST_ARM) || (state_ff == ST_RUN);

endmodule // dpcu_unit

// [verilog/dpcu_top.sv]
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module dpcu_top
  import dpcu_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [AW-1:0]     paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Unit pins {u1b, u1a, u0b, u0a}
  input  wire logic [NUPIN-1:0]  upin_i,
  output logic      [NUPIN-1:0]  upin_o,
  output logic      [NUPIN-1:0]  upin_oe_o,
  // Multi-channel capture sources
  input  wire logic [NMCIN-1:0]  mc_in_i,
  // Interrupt
  output logic                   irq_o
);

  logic [CTRLW-1:0] ctrl_ff   [NUNIT];
  logic [CW-1:0]    period_ff [NUNIT];
  logic [CW-1:0]    duta_ff   [NUNIT];
  logic [CW-1:0]    dutb_ff   [NUNIT];
  logic [CW-1:0]    loadv_ff  [NUNIT];
  logic [NUNIT-1:0] start_ff;
  logic [MCW-1:0]   mcctrl_ff;
  logic [NMC-1:0]   mcsw_ff;
  logic [CW-1:0]    mccap_ff  [NMC];
  logic             link_ld_ff;
  logic [NINT-1:0]  int_stat_ff;
  logic [NINT-1:0]  int_en_ff;
  logic [NINT-1:0]  nxt_int_stat;
  logic [NINT-1:0]  int_ev;
  logic             irq_ff;
  logic [NUPIN-1:0] oe_ff;
  logic [NIN-1:0]   sync1_ff;
  logic [NIN-1:0]   sync2_ff;
  logic [NIN-1:0]   sync3_ff;
  logic [NIN-1:0]   lvl_ff;
  logic [NIN-1:0]   rise_w;
  logic [NIN-1:0]   fall_w;
  logic [NMC-1:0]   mc_ev_w;
  logic [CW-1:0]    ucnt_w    [NUNIT];
  logic [CW-1:0]    ucap_w    [NUNIT];
  logic [NUNIT-1:0] ubusy_w;
  logic [NUNIT-1:0] ev_per_w;
  logic [NUNIT-1:0] ev_cap_w;
  logic [NUNIT-1:0] ev_ovf_w;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic [31:0]      rdata;
  logic             mapped;
  logic             access;
  logic             wr_done;
  logic             uidx;
  logic [4:0]       uofs;
  logic             in_unit;

  // Pins change state only once sync2 and sync3 agree
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      lvl_ff   <= '0;
    end else if (ce_i) begin
      sync1_ff <= {mc_in_i, upin_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff   <= (sync2_ff & sync3_ff) | (lvl_ff & (sync2_ff | sync3_ff));
    end
  end

  assign rise_w = ~lvl_ff & sync2_ff & sync3_ff;
  assign fall_w = lvl_ff & ~sync2_ff & ~sync3_ff;

  dpcu_unit_if uif [NUNIT] ();

  genvar g;
  generate
    for (g = 0; g < NUNIT; g++) begin : g_unit
      assign uif[g].en       = ctrl_ff[g][B_EN];
      assign uif[g].cap_mode = ctrl_ff[g][B_MODE];
      assign uif[g].capsel   = ctrl_ff[g][B_CAPSEL];
      assign uif[g].meth     = dpcu_meth_t'(ctrl_ff[g][B_METH +: 2]);
      assign uif[g].pola     = ctrl_ff[g][B_POLA];
      assign uif[g].polb     = ctrl_ff[g][B_POLB];
      assign uif[g].start    = start_ff[g];
      assign uif[g].period   = period_ff[g];
      assign uif[g].duty_a   = duta_ff[g];
      assign uif[g].duty_b   = dutb_ff[g];
      assign uif[g].load_val = loadv_ff[g];
      assign uif[g].load     = (g == 0) ? link_ld_ff : 1'b0;
      assign uif[g].rise_a   = rise_w[2*g];
      assign uif[g].fall_a   = fall_w[2*g];
      assign uif[g].rise_b   = rise_w[2*g+1];
      assign uif[g].fall_b   = fall_w[2*g+1];
      assign ucnt_w[g]       = uif[g].cnt;
      assign ucap_w[g]       = uif[g].cap_val;
      assign ubusy_w[g]      = uif[g].busy;
      assign ev_per_w[g]     = uif[g].ev_period;
      assign ev_cap_w[g]     = uif[g].ev_cap;
      assign ev_ovf_w[g]     = uif[g].ev_ovf;
      assign upin_o[2*g]     = uif[g].pwm_a;
      assign upin_o[2*g+1]   = uif[g].pwm_b;

      dpcu_unit u_unit (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .u          (uif[g])
      );
    end
  endgenerate

  // Multi-channel capture hangs off the second unit's counter only
  generate
    for (g = 0; g < NMC; g++) begin : g_mc
      logic [SELW-1:0] sel;
      logic [1:0]      edg;
      assign sel = mcctrl_ff[B_MC_SEL + SELW*g +: SELW];
      assign edg = mcctrl_ff[B_MC_EDGE + 2*g +: 2];
      assign mc_ev_w[g] = mcctrl_ff[B_MC_EN] && ctrl_ff[1][B_EN] &&
                          (mcctrl_ff[B_MC_SW] ? mcsw_ff[g] :
                           ((rise_w[NUPIN + sel] && edg[0]) || (fall_w[NUPIN + sel] && edg[1])));

      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          mccap_ff[g] <= CNT_ZERO;
        end else if (ce_i && mc_ev_w[g]) begin
          mccap_ff[g] <= ucnt_w[1];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      link_ld_ff <= 1'b0;
    end else if (ce_i) begin
      link_ld_ff <= mcctrl_ff[B_MC_LINK] && (|mc_ev_w);
    end
  end

  // Pins drive only while their unit makes PWM; in capture they are inputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      oe_ff <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NUPIN; i++) begin
        oe_ff[i] <= ctrl_ff[i/2][B_EN] && !ctrl_ff[i/2][B_MODE];
      end
    end
  end

  // APB: one wait state; writes land on the completing edge
  assign access  = psel_i && penable_i && !pready_ff;
  assign wr_done = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff && ce_i;
  assign uidx    = paddr_i[UNIT_BIT];
  assign uofs    = paddr_i[4:0];
  assign in_unit = paddr_i < (UNIT_STRIDE + UNIT_STRIDE);

  always_comb begin
    rdata  = '0;
    mapped = 1'b1;
    if (in_unit) begin
      case (uofs)
        U_CTRL:   rdata = {23'h000000, ubusy_w[uidx], 1'b0, ctrl_ff[uidx]};
        U_PERIOD: rdata = {16'h0000, period_ff[uidx]};
        U_DUTYA:  rdata = {16'h0000, duta_ff[uidx]};
        U_DUTYB:  rdata = {16'h0000, dutb_ff[uidx]};
        U_CAPT:   rdata = {16'h0000, ucap_w[uidx]};
        U_LOAD:   rdata = {16'h0000, loadv_ff[uidx]};
        U_CNT:    rdata = {16'h0000, ucnt_w[uidx]};
        default:  mapped = 1'b0;
      endcase
    end else begin
      case (paddr_i)
        MC_CTRL:                 rdata = {4'h0, mcctrl_ff};
        MC_SW:                   rdata = '0;
        MC_CAPTURE_CHANNEL_ZERO:                 rdata = {16'h0000, mccap_ff[0]};
        MC_CAPTURE_CHANNEL_ZERO + MC_STEP:       rdata = {16'h0000, mccap_ff[1]};
        MC_CAPTURE_CHANNEL_ZERO + 2 * MC_STEP:   rdata = {16'h0000, mccap_ff[2]};
        MC_CAPTURE_CHANNEL_ZERO + 3 * MC_STEP:   rdata = {16'h0000, mccap_ff[3]};
        INT_STAT:                rdata = {22'h000000, int_stat_ff};
        INT_EN:                  rdata = {22'h000000, int_en_ff};
        INT_CLR:                 rdata = '0;
        default:                 mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (ce_i) begin
      pready_ff  <= access;
      pslverr_ff <= access && !mapped;
      prdata_ff  <= (access && !pwrite_i) ? rdata : '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUNIT; i++) begin
        ctrl_ff[i]   <= '0;
        period_ff[i] <= CNT_MAX;
        duta_ff[i]   <= CNT_ZERO;
        dutb_ff[i]   <= CNT_ZERO;
        loadv_ff[i]  <= CNT_ZERO;
      end
    end else if (wr_done && in_unit) begin
      case (uofs)
        U_CTRL:   ctrl_ff[uidx]   <= pwdata_i[CTRLW-1:0];
        U_PERIOD: period_ff[uidx] <= pwdata_i[CW-1:0];
        U_DUTYA:  duta_ff[uidx]   <= pwdata_i[CW-1:0];
        U_DUTYB:  dutb_ff[uidx]   <= pwdata_i[CW-1:0];
        U_LOAD:   loadv_ff[uidx]  <= pwdata_i[CW-1:0];
        default: ;
      endcase
    end
  end

  // Start and software-capture strobes live one cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      start_ff <= '0;
      mcsw_ff  <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NUNIT; i++) begin
        start_ff[i] <= wr_done && in_unit && uidx == i[0] && uofs == U_CTRL && pwdata_i[B_START];
      end
      mcsw_ff <= (wr_done && paddr_i == MC_SW) ? pwdata_i[NMC-1:0] : '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mcctrl_ff <= '0;
      int_en_ff <= '0;
    end else if (wr_done && !in_unit) begin
      if (paddr_i == MC_CTRL) begin
        mcctrl_ff <= pwdata_i[MCW-1:0];
      end
      if (paddr_i == INT_EN) begin
        int_en_ff <= pwdata_i[NINT-1:0];
      end
    end
  end

  // An event in the clearing cycle survives the clear
  always_comb begin
    int_ev = '0;
    int_ev[I_PWM +: NUNIT] = ev_per_w;
    int_ev[I_CAP +: NUNIT] = ev_cap_w;
    int_ev[I_MC +: NMC]    = mc_ev_w;
    int_ev[I_OVF +: NUNIT] = ev_ovf_w;
    nxt_int_stat = int_stat_ff | int_ev;
    if (wr_done && paddr_i == INT_CLR) begin
      nxt_int_stat = (int_stat_ff & ~pwdata_i[NINT-1:0]) | int_ev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      int_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end else if (ce_i) begin
      int_stat_ff <= nxt_int_stat;
      irq_ff      <= |(nxt_int_stat & int_en_ff);
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign upin_oe_o = oe_ff;
  assign irq_o     = irq_ff;

endmodule // dpcu_top

// [tb/dpcu_checker.sv]
`timescale 1ns/1ps
module dpcu_checker
  import dpcu_pkg::*;
(
  // Clock, reset, enable
  input wire logic             core_clk_i,
  input wire logic             srst_i,
  input wire logic             ce_i,
  // APB
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [AW-1:0]    paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  // Pins and interrupt
  input wire logic [NUPIN-1:0] upin_i,
  input wire logic [NUPIN-1:0] upin_o,
  input wire logic [NUPIN-1:0] upin_oe_o,
  input wire logic [NMCIN-1:0] mc_in_i,
  input wire logic             irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_ready_pulse: assert property (pready_o && ce_i |=> !pready_o)
    else $error("pready held longer than one cycle");
  chk_ready_timing: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
    else $error("pready late after first access cycle");
  chk_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without an access phase");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside pready");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (psel_i && penable_i && !pready_o && ce_i && paddr_i > INT_CLR |=> pslverr_o)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel_i && penable_i && !pready_o && ce_i && paddr_i == INT_EN |=> !pslverr_o)
    else $error("mapped access refused");
  chk_irq_mask: assert property (psel_i && penable_i && pready_o && pwrite_i && ce_i && paddr_i == INT_EN &&
    pwdata_i[NINT-1:0] == 10'h0 |-> ##2 !irq_o)
    else $error("irq high with all causes disabled");
  // Reset must quieten outputs, so this one is not disabled by it
  chk_reset_quiet: assert property (disable iff (1'b0) srst_i |=> !pready_o && !irq_o && upin_oe_o == 4'h0)
    else $error("outputs active after reset");
endmodule // dpcu_checker

bind dpcu_top dpcu_checker chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .upin_i(upin_i), .upin_o(upin_o), .upin_oe_o(upin_oe_o),
  .mc_in_i(mc_in_i), .irq_o(irq_o));

// [tb/dpcu_pin_model.sv]
`timescale 1ns/1ps
module dpcu_pin_model
  import dpcu_pkg::*;
(
  // Block side
  input  wire logic [NUPIN-1:0] upin_o,
  input  wire logic [NUPIN-1:0] upin_oe_o,
  // Levels seen by the block
  output logic      [NUPIN-1:0] upin_i,
  output logic      [NMCIN-1:0] mc_in_i
);
  // Pulse sources, set by the bench just after a clock edge
  logic [NUPIN-1:0] ext = 4'h0;
  logic [NMCIN-1:0] src = 16'h0;

  // A pin the block drives shows the block's level, else the source's
  assign upin_i  = (upin_oe_o & upin_o) | (~upin_oe_o & ext);
  assign mc_in_i = src;
endmodule // dpcu_pin_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import dpcu_pkg::*;
  logic             core_clk_i, srst_i, ce_i, psel_i, penable_i, pwrite_i;
  logic [AW-1:0]    paddr_i;
  logic [31:0]      pwdata_i, rd, v;
  wire  [31:0]      prdata_o;
  wire              pready_o, pslverr_o, irq_o;
  wire  [NUPIN-1:0] upin_i, upin_o, upin_oe_o;
  wire  [NMCIN-1:0] mc_in_i;
  logic             er;
  int               bad_count, checks_done, p, s;
  int               hi[4];
  int               pwm_exp[4] = '{6, 8, 8, 20};

  dpcu_top dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .upin_i(upin_i), .upin_o(upin_o), .upin_oe_o(upin_oe_o), .mc_in_i(mc_in_i),
    .irq_o(irq_o));
  dpcu_pin_model pins_u (.upin_o(upin_o), .upin_oe_o(upin_oe_o), .upin_i(upin_i), .mc_in_i(mc_in_i));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  function automatic logic [AW-1:0] ua(input int g, input logic [4:0] off);
    return AW'(g) * UNIT_STRIDE + AW'(off);
  endfunction

  // One APB transfer; ends one edge after release so calls never collide
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // Looked at mid-cycle: registered answers stand settled up to the next edge
    do begin
      @(negedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n == 50) begin
      check(32'h0, 32'h1);
      stop_test;
    end
    rd = prdata_o;
    er = pslverr_o;
    @(posedge core_clk_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [AW-1:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  initial begin
    srst_i    = 1'b1;
    ce_i      = 1'b1;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 7'h0;
    pwdata_i  = 32'h0;
    cyc(20);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    // Reset values and a refused access
    for (int g = 0; g < 2; g++) begin
      rdx(ua(g, U_PERIOD));
      check(rd, 32'h0000FFFF);
    end
    rdx(7'h64);
    check(er, 32'h1);
    check(rd, 32'h0);
    // PWM: separate periods per unit, separate duties, one inverted output
    wr(ua(0, U_PERIOD), 32'h9);
    wr(ua(0, U_DUTYA), 32'h3);
    wr(ua(0, U_DUTYB), 32'h6);
    wr(ua(1, U_PERIOD), 32'h4);
    wr(ua(1, U_DUTYA), 32'h2);
    wr(ua(1, U_DUTYB), 32'h5);
    wr(ua(1, U_CTRL), 32'h1);
    wr(ua(0, U_CTRL), 32'h41);
    cyc(30);
    hi = '{0, 0, 0, 0};
    // 20 cycles hold whole periods of both units, so phase does not matter
    repeat (20) begin
      @(negedge core_clk_i);
      for (int k = 0; k < 4; k++) hi[k] += (upin_o[k] === 1'b1);
    end
    for (int k = 0; k < 4; k++) check(hi[k], pwm_exp[k]);
    check(upin_oe_o, 32'hF);
    @(posedge core_clk_i);
    rdx(INT_STAT);
    check(rd[1:0], 32'h3);
    check(irq_o, 32'h0);
    wr(INT_EN, 32'h1);
    cyc(3);
    check(irq_o, 32'h1);
    wr(INT_EN, 32'h0);
    cyc(3);
    check(irq_o, 32'h0);
    wr(ua(0, U_CTRL), 32'h0);
    wr(ua(1, U_CTRL), 32'h0);
    wr(INT_CLR, 32'h3FF);
    rdx(INT_STAT);
    check(rd, 32'h0);
    // Single-shot capture, every method, A and B pins of both units
    wr(INT_EN, 32'h3 << I_CAP);
    for (int g = 0; g < 2; g++) begin
      for (int m = 0; m < 4; m++) begin
        p = 2 * g + (m % 2);
        pins_u.ext[p] <= m[0];
        cyc(8);
        wr(ua(g, U_CTRL), 32'h83 | (32'(m % 2) << B_CAPSEL) | (32'(m) << B_METH));
        if (m >= 2) begin
          cyc(5);
          pins_u.ext[p] <= ~m[0];
        end
        cyc(40);
        pins_u.ext[p] <= pins_u.ext[p] ^ 1'b1;
        cyc(10);
        rdx(ua(g, U_CAPT));
        check(rd >= 32'd38 && rd <= 32'd52, 32'h1);
        rdx(ua(g, U_CNT));
        v = rd;
        cyc(5);
        rdx(ua(g, U_CNT));
        check(rd, v);
        rdx(ua(g, U_CTRL));
        check(rd[B_BUSY], 32'h0);
        rdx(INT_STAT);
        check(rd[I_CAP + g], 32'h1);
        check(irq_o, 32'h1);
        wr(INT_CLR, 32'h1 << (I_CAP + g));
        cyc(2);
        check(irq_o, 32'h0);
      end
    end
    // Multi-channel capture: each channel, each edge choice, boundary sources
    wr(ua(1, U_CTRL), 32'h1);
    for (int i = 0; i < 4; i++) begin
      for (int e = 1; e < 4; e++) begin
        s = i * 5;
        wr(MC_CTRL, 32'h1 | (32'(s) << (B_MC_SEL + 4 * i)) | (32'(e) << (B_MC_EDGE + 2 * i)));
        cyc(6);
        wr(INT_CLR, 32'hF0);
        pins_u.src[s] <= 1'b1;
        cyc(8);
        rdx(INT_STAT);
        check(rd[7:4], e[0] ? (32'h1 << i) : 32'h0);
        wr(INT_CLR, 32'hF0);
        pins_u.src[s] <= 1'b0;
        cyc(8);
        rdx(INT_STAT);
        check(rd[7:4], e[1] ? (32'h1 << i) : 32'h0);
      end
    end
    // Software capture with the load link to the first unit
    wr(ua(0, U_LOAD), 32'h1234);
    wr(INT_CLR, 32'h3FF);
    wr(MC_CTRL, 32'h7);
    wr(MC_SW, 32'hF);
    cyc(4);
    rdx(INT_STAT);
    check(rd[7:4], 32'hF);
    rdx(ua(0, U_CNT));
    check(rd, 32'h1234);
    // Clock enable low freezes every flop, the running PWM outputs included
    ce_i <= 1'b0;
    @(negedge core_clk_i);
    v = 32'(upin_o);
    cyc(6);
    @(negedge core_clk_i);
    check(32'(upin_o), v);
    stop_test;
  end
endmodule // testbench
